// ===== rtl/pioxb_map.svh
`ifndef PIOXB_MAP_SVH
`define PIOXB_MAP_SVH

// ==========================================================
// Register offsets (byte addresses, one aligned word each)
`define PIOXB_OFS_CFG_A 8'h00
`define PIOXB_OFS_CFG_B 8'h04
`define PIOXB_OFS_CFG_C 8'h08
`define PIOXB_OFS_P1_INMODE 8'h0C
`define PIOXB_OFS_BIT_ACC 8'h14
`define PIOXB_OFS_PDATA 8'h20
`define PIOXB_OFS_PMODE 8'h40
`define PIOXB_OFS_PLATCH 8'h60
`define PIOXB_OFS_END 8'h80

// ==========================================================
// Field positions
`define PIOXB_A_I2C 0
`define PIOXB_A_SER0 2
`define PIOXB_B_INT0 2
`define PIOXB_B_INT1 4
`define PIOXB_C_CNV 0
`define PIOXB_C_EXTMEM_LOW 1
`define PIOXB_C_SER1 2
`define PIOXB_C_GLOBAL_EN 6
`define PIOXB_C_PULLUP_DIS 7
`define PIOXB_BIT_VAL 7
`define PIOXB_P0_ALE 5
`define PIOXB_P0_RD 6
`define PIOXB_P0_WR 7

// ==========================================================
// Reset values and responses
`define PIOXB_RST_CFG 8'h00
`define PIOXB_RST_LATCH 8'hFF
`define PIOXB_RST_MODE 8'h00
`define PIOXB_RST_INMODE 8'hFF
`define PIOXB_RESP_OKAY 2'b00
`define PIOXB_RESP_SLVERR 2'b10

`endif

// ===== rtl/pioxb_pkg.sv
package pioxb_pkg;

  // ==========================================================
  // Crossbar signal codes, in priority order; zero means plain port pin
  typedef logic [3:0] pioxb_sig_t;
  localparam pioxb_sig_t SIG_NONE = 4'h0;
  localparam pioxb_sig_t SIG_S0_TX = 4'h1;
  localparam pioxb_sig_t SIG_S0_RX = 4'h2;
  localparam pioxb_sig_t SIG_SDA = 4'h3;
  localparam pioxb_sig_t SIG_SCL = 4'h4;
  localparam pioxb_sig_t SIG_S1_TX = 4'h5;
  localparam pioxb_sig_t SIG_S1_RX = 4'h6;
  localparam pioxb_sig_t SIG_INT0 = 4'h7;
  localparam pioxb_sig_t SIG_INT1 = 4'h8;
  localparam pioxb_sig_t SIG_CNV = 4'h9;

  // One code per lower-port pin, pin 0 of port 0 at index 0
  typedef logic [31:0][3:0] pioxb_sel_t;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP = 2'b10
  } pioxb_wr_st_t;

endpackage

// ===== rtl/pioxb_sync.sv
`timescale 1ns/10ps
module pioxb_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Pin levels
  input wire logic [63:0] pin_raw,
  output logic [63:0] pin_level
);
  logic [63:0] s1_q;
  logic [63:0] s2_q;
  logic [63:0] s3_q;

  // ==========================================================
  // Three stages; a change is taken once stages two and three agree,
  // which rejects a single-cycle glitch leaking through stage one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      pin_level <= '1;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_level <= (s2_q & s3_q) | (pin_level & (s2_q ^ s3_q));
    end
  end
endmodule

// ===== rtl/pioxb_alloc.sv
`timescale 1ns/10ps
module pioxb_alloc (
  // Skipped pins and peripheral group enables, in priority order
  input wire logic [31:0] skip,
  input wire logic [5:0] grp_en,
  // Signal code per lower-port pin
  output pioxb_pkg::pioxb_sel_t pin_sel
);
  import pioxb_pkg::*;

  localparam pioxb_sig_t GRP_FIRST [0:5] = '{SIG_S0_TX, SIG_SDA, SIG_S1_TX, SIG_INT0, SIG_INT1, SIG_CNV};
  localparam int GRP_SIZE [0:5] = '{2, 2, 2, 1, 1, 1};

  // ==========================================================
  // Pure combinational map, so a configuration write shows on the pins
  // in the cycle after the write edge
  always_comb begin
    int nfree;
    int nreq;
    int k;
    pioxb_sig_t req [0:8];
    nfree = 0;
    nreq = 0;
    k = 0;
    for (int i = 0; i < 9; i++) begin
      req[i] = SIG_NONE;
    end
    for (int i = 0; i < 32; i++) begin
      if (!skip[i]) begin
        nfree++;
      end
    end
    // A group gets all its pins or none
    for (int g = 0; g < 6; g++) begin
      if (grp_en[g] && (nreq + GRP_SIZE[g] <= nfree)) begin
        for (int j = 0; j < GRP_SIZE[g]; j++) begin
          req[nreq] = 4'(GRP_FIRST[g] + 4'(j));
          nreq++;
        end
      end
    end
    pin_sel = '0;
    for (int i = 0; i < 32; i++) begin
      if (!skip[i]) begin
        if (k < nreq) begin
          pin_sel[i] = req[k];
        end
        k++;
      end
    end
  end
endmodule

// ===== rtl/pioxb_top.sv
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "pioxb_map.svh"
module pioxb_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port pins
  input wire logic [63:0] pin_in,
  output logic [63:0] pin_out,
  output logic [63:0] pin_oe,
  output logic [63:0] pullup_en,
  // Peripheral outputs toward the pins
  input wire logic serial0_transmit,
  input wire logic serial0_receive_drive,
  input wire logic serial0_mode0,
  input wire logic sda_drive,
  input wire logic scl_drive,
  input wire logic serial1_transmit,
  input wire logic serial1_receive_drive,
  input wire logic serial1_mode0,
  // Peripheral inputs from the pins
  output logic serial0_receive,
  output logic sda_level,
  output logic scl_level,
  output logic serial1_receive,
  output logic ext_int0_level,
  output logic ext_int1_level,
  output logic conversion_start_input,
  // External memory interface
  input wire logic external_data_move,
  input wire logic extmem_muxed,
  input wire logic extmem_upper,
  input wire logic [31:0] extmem_out,
  input wire logic [31:0] extmem_oe
);
  import pioxb_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0] crossbar_cfg_a_q;
  logic [7:0] crossbar_cfg_b_q;
  logic [7:0] crossbar_cfg_c_q;
  logic [7:0] port1_input_mode_reg_q;
  logic [7:0] bit_idx_q;
  logic [7:0][7:0] latch_q;
  logic [7:0][7:0] port_output_mode_reg_q;

  logic [63:0] pin_level;
  logic [31:0] skip;
  logic [5:0] grp_en;
  pioxb_sel_t pin_sel;
  logic crossbar_global_enable;
  logic extmem_low_port_enable;
  logic [15:0] sig_val;
  logic [15:0] sig_drv;
  logic [15:0] sig_od;

  pioxb_wr_st_t wr_st_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic do_wr;
  logic [31:0] rdata_d;

  assign crossbar_global_enable = crossbar_cfg_c_q[`PIOXB_C_GLOBAL_EN];
  assign extmem_low_port_enable = crossbar_cfg_c_q[`PIOXB_C_EXTMEM_LOW];

  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'b00) && ((a <= `PIOXB_OFS_BIT_ACC) || ((a >= `PIOXB_OFS_PDATA) && (a < `PIOXB_OFS_END)));
  endfunction

  // ==========================================================
  // Pin sampling and crossbar allocation
  pioxb_sync u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin_raw(pin_in),
    .pin_level(pin_level)
  );

  always_comb begin
    skip = '0;
    skip[15:8] = ~port1_input_mode_reg_q;
    if (extmem_low_port_enable) begin
      skip[`PIOXB_P0_RD] = 1'b1;
      skip[`PIOXB_P0_WR] = 1'b1;
      skip[`PIOXB_P0_ALE] = extmem_muxed;
    end
  end

  assign grp_en = {crossbar_cfg_c_q[`PIOXB_C_CNV], crossbar_cfg_b_q[`PIOXB_B_INT1],
                   crossbar_cfg_b_q[`PIOXB_B_INT0], crossbar_cfg_c_q[`PIOXB_C_SER1],
                   crossbar_cfg_a_q[`PIOXB_A_I2C], crossbar_cfg_a_q[`PIOXB_A_SER0]};

  pioxb_alloc u_alloc (
    .skip(skip),
    .grp_en(grp_en),
    .pin_sel(pin_sel)
  );

  // ==========================================================
  // Per-signal output value, drive and forced open-drain
  always_comb begin
    sig_val = '1;
    sig_drv = '0;
    sig_od = '0;
    sig_val[SIG_S0_TX] = serial0_transmit;
    sig_drv[SIG_S0_TX] = 1'b1;
    sig_val[SIG_S0_RX] = serial0_receive_drive;
    sig_drv[SIG_S0_RX] = serial0_mode0;
    sig_od[SIG_S0_RX] = serial0_mode0;
    sig_val[SIG_SDA] = sda_drive;
    sig_drv[SIG_SDA] = 1'b1;
    sig_od[SIG_SDA] = 1'b1;
    sig_val[SIG_SCL] = scl_drive;
    sig_drv[SIG_SCL] = 1'b1;
    sig_od[SIG_SCL] = 1'b1;
    sig_val[SIG_S1_TX] = serial1_transmit;
    sig_drv[SIG_S1_TX] = 1'b1;
    sig_val[SIG_S1_RX] = serial1_receive_drive;
    sig_drv[SIG_S1_RX] = serial1_mode0;
    sig_od[SIG_S1_RX] = serial1_mode0;
  end

  // ==========================================================
  // Pin drivers; external memory overrides only during its moves
  always_comb begin
    pioxb_sig_t code;
    logic val;
    logic drv;
    logic od;
    logic external_memory_interface;
    code = SIG_NONE;
    val = 1'b1;
    drv = 1'b0;
    od = 1'b1;
    external_memory_interface = 1'b0;
    for (int i = 0; i < 64; i++) begin
      code = (i < 32) ? pin_sel[i % 32] : SIG_NONE;
      val = latch_q[i / 8][i % 8];
      drv = 1'b1;
      od = ~port_output_mode_reg_q[i / 8][i % 8];
      if (code != SIG_NONE) begin
        val = sig_val[code];
        drv = sig_drv[code];
        od = od | sig_od[code];
      end
      external_memory_interface = external_data_move && ((i < 32) ? !extmem_upper : extmem_upper) && extmem_oe[i % 32];
      if (external_memory_interface) begin
        val = extmem_out[i % 32];
        drv = 1'b1;
      end
      if ((i < 32) && !crossbar_global_enable) begin
        drv = 1'b0;
      end
      pin_out[i] = od ? 1'b0 : val;
      pin_oe[i] = drv && (od ? !val : 1'b1);
      // An output driving low would fight its own pull-up
      pullup_en[i] = !crossbar_cfg_c_q[`PIOXB_C_PULLUP_DIS] && !(pin_oe[i] && !pin_out[i]) &&
                     !((i >= 8) && (i < 16) && !port1_input_mode_reg_q[i % 8]);
    end
  end

  // ==========================================================
  // Peripheral inputs; idle high when the signal has no pin
  always_comb begin
    serial0_receive = 1'b1;
    sda_level = 1'b1;
    scl_level = 1'b1;
    serial1_receive = 1'b1;
    ext_int0_level = 1'b1;
    ext_int1_level = 1'b1;
    conversion_start_input = 1'b1;
    for (int i = 0; i < 32; i++) begin
      unique case (pin_sel[i])
        SIG_S0_RX: serial0_receive = pin_level[i];
        SIG_SDA: sda_level = pin_level[i];
        SIG_SCL: scl_level = pin_level[i];
        SIG_S1_RX: serial1_receive = pin_level[i];
        SIG_INT0: ext_int0_level = pin_level[i];
        SIG_INT1: ext_int1_level = pin_level[i];
        SIG_CNV: conversion_start_input = pin_level[i];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite write channel: address and data in either order
  assign s_axi_awready = (wr_st_q == WR_COLLECT) && !aw_have_q;
  assign s_axi_wready = (wr_st_q == WR_COLLECT) && !w_have_q;
  assign s_axi_bvalid = (wr_st_q == WR_RESP);
  assign do_wr = (wr_st_q == WR_COLLECT) && aw_have_q && w_have_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (do_wr) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_st_q <= WR_COLLECT;
      s_axi_bresp <= `PIOXB_RESP_OKAY;
    end else begin
      unique case (wr_st_q)
        WR_COLLECT: begin
          if (do_wr) begin
            wr_st_q <= WR_RESP;
            s_axi_bresp <= addr_ok(awaddr_q) ? `PIOXB_RESP_OKAY : `PIOXB_RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_st_q <= WR_COLLECT;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Register writes; latch view offsets are read-only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      crossbar_cfg_a_q <= `PIOXB_RST_CFG;
      crossbar_cfg_b_q <= `PIOXB_RST_CFG;
      crossbar_cfg_c_q <= `PIOXB_RST_CFG;
      port1_input_mode_reg_q <= `PIOXB_RST_INMODE;
      bit_idx_q <= 8'h00;
      latch_q <= {8{`PIOXB_RST_LATCH}};
      port_output_mode_reg_q <= {8{`PIOXB_RST_MODE}};
    end else if (do_wr && wstrb0_q) begin
      if (awaddr_q == `PIOXB_OFS_CFG_A) begin
        crossbar_cfg_a_q <= wdata_q;
      end else if (awaddr_q == `PIOXB_OFS_CFG_B) begin
        crossbar_cfg_b_q <= wdata_q;
      end else if (awaddr_q == `PIOXB_OFS_CFG_C) begin
        crossbar_cfg_c_q <= wdata_q;
      end else if (awaddr_q == `PIOXB_OFS_P1_INMODE) begin
        port1_input_mode_reg_q <= wdata_q;
      end else if (awaddr_q == `PIOXB_OFS_BIT_ACC) begin
        bit_idx_q <= {3'b000, wdata_q[4:0]};
        latch_q[wdata_q[4:3]][wdata_q[2:0]] <= wdata_q[`PIOXB_BIT_VAL];
      end else if ((awaddr_q[7:5] == 3'b001) && (awaddr_q[1:0] == 2'b00)) begin
        latch_q[awaddr_q[4:2]] <= wdata_q;
      end else if ((awaddr_q[7:5] == 3'b010) && (awaddr_q[1:0] == 2'b00)) begin
        port_output_mode_reg_q[awaddr_q[4:2]] <= wdata_q;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    logic [7:0] lvl;
    lvl = pin_level[s_axi_araddr[4:2] * 8 +: 8];
    if (s_axi_araddr[4:2] == 3'd1) begin
      lvl = lvl & port1_input_mode_reg_q;
    end
    rdata_d = 32'h0000_0000;
    if (s_axi_araddr == `PIOXB_OFS_CFG_A) begin
      rdata_d[7:0] = crossbar_cfg_a_q;
    end else if (s_axi_araddr == `PIOXB_OFS_CFG_B) begin
      rdata_d[7:0] = crossbar_cfg_b_q;
    end else if (s_axi_araddr == `PIOXB_OFS_CFG_C) begin
      rdata_d[7:0] = crossbar_cfg_c_q;
    end else if (s_axi_araddr == `PIOXB_OFS_P1_INMODE) begin
      rdata_d[7:0] = port1_input_mode_reg_q;
    end else if (s_axi_araddr == `PIOXB_OFS_BIT_ACC) begin
      rdata_d[7:0] = {pin_level[bit_idx_q[4:0]] & ~((bit_idx_q[4:3] == 2'b01) & ~port1_input_mode_reg_q[bit_idx_q[2:0]]),
                      bit_idx_q[6:0]};
    end else if ((s_axi_araddr[7:5] == 3'b001) && (s_axi_araddr[1:0] == 2'b00)) begin
      rdata_d[7:0] = lvl;
    end else if ((s_axi_araddr[7:5] == 3'b010) && (s_axi_araddr[1:0] == 2'b00)) begin
      rdata_d[7:0] = port_output_mode_reg_q[s_axi_araddr[4:2]];
    end else if ((s_axi_araddr[7:5] == 3'b011) && (s_axi_araddr[1:0] == 2'b00)) begin
      rdata_d[7:0] = latch_q[s_axi_araddr[4:2]];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PIOXB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? `PIOXB_RESP_OKAY : `PIOXB_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  logic s1_tx_pin;
  logic s1_rx_pin;
  logic s0_any;
  always_comb begin
    s1_tx_pin = 1'b0;
    s1_rx_pin = 1'b0;
    s0_any = 1'b0;
    for (int i = 0; i < 32; i++) begin
      s1_tx_pin = s1_tx_pin | (pin_sel[i] == SIG_S1_TX);
      s1_rx_pin = s1_rx_pin | (pin_sel[i] == SIG_S1_RX);
      s0_any = s0_any | (pin_sel[i] == SIG_S0_TX) | (pin_sel[i] == SIG_S0_RX);
    end
  end

  sequence port0_write_s;
    do_wr && wstrb0_q && (awaddr_q == `PIOXB_OFS_PDATA);
  endsequence

  sequence p1_read_s;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == (`PIOXB_OFS_PDATA + 8'h04));
  endsequence

  lower_oe_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !crossbar_global_enable |-> (pin_oe[31:0] == 32'h0000_0000))
    else $error("lower pin driven while crossbar disabled");

  serial0_fixed_a: assert property (@(posedge core_clk) disable iff (!resetn)
    crossbar_cfg_a_q[`PIOXB_A_SER0] |-> (pin_sel[0] == SIG_S0_TX) && (pin_sel[1] == SIG_S0_RX))
    else $error("serial 0 not on pins 0 and 1");

  serial0_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !crossbar_cfg_a_q[`PIOXB_A_SER0] |-> !s0_any)
    else $error("disabled serial 0 holds a pin");

  serial1_pair_a: assert property (@(posedge core_clk) disable iff (!resetn)
    s1_tx_pin == s1_rx_pin)
    else $error("serial 1 signals split");

  strobe_skip_a: assert property (@(posedge core_clk) disable iff (!resetn)
    extmem_low_port_enable |-> (pin_sel[`PIOXB_P0_RD] == SIG_NONE) && (pin_sel[`PIOXB_P0_WR] == SIG_NONE))
    else $error("strobe pin given to a peripheral");

  rx_input_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (pin_sel[1] == SIG_S0_RX) && !serial0_mode0 |-> !pin_oe[1])
    else $error("receive pin drives");

  sda_open_drain_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (pin_sel[2] == SIG_SDA) |-> !(pin_oe[2] && pin_out[2]))
    else $error("two-wire pin driven high");

  latch_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    port0_write_s |=> (latch_q[0] == $past(wdata_q)) && s_axi_bvalid)
    else $error("port latch write lost");

  analog_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    p1_read_s |=> s_axi_rvalid && ((s_axi_rdata[7:0] & ~$past(port1_input_mode_reg_q)) == 8'h00))
    else $error("analog pin read not zero");

  write_resp_a: assert property (@(posedge core_clk) disable iff (!resetn)
    do_wr |=> s_axi_bvalid && (s_axi_bresp == (addr_ok(awaddr_q) ? `PIOXB_RESP_OKAY : `PIOXB_RESP_SLVERR)))
    else $error("write response missing or wrong");
endmodule

// ===== testbench/pioxb_board.sv
`timescale 1ns/10ps
module pioxb_board (
  // Clock
  input wire logic core_clk,
  // Device pin drivers
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe,
  input wire logic [63:0] pullup_en,
  // Board drivers
  input wire logic [63:0] ext_val,
  input wire logic [63:0] ext_en,
  output logic [63:0] pin_in
);
  logic [63:0] float_q = 64'h0000_0000_0000_0000;
  // A floating pin wanders, so a stale level never passes for a drive
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_q[i];
    end
  end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  logic core_clk = 0, resetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [63:0] pin_in, pin_out, pin_oe, pullup_en, ext_val = 0, ext_en = 0;
  logic s0_tx = 1, s1_tx = 1, muxed = 0;
  logic s0_mode0 = 0, s0_rxd = 1, sda_d = 1, scl_d = 1, xmove = 0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] xoe = 32'h0000_0000;
  logic s0_rx, s1_rx, sda_l, scl_l, int0_l, int1_l, cnv_l;
  int mismatches = 0, compares = 0, cycles = 0;
  initial forever #10 core_clk = ~core_clk;
  pioxb_top dut (.core_clk(core_clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .serial0_transmit(s0_tx), .serial0_receive_drive(s0_rxd), .serial0_mode0(s0_mode0),
    .sda_drive(sda_d), .scl_drive(scl_d), .serial1_transmit(s1_tx), .serial1_receive_drive(1'b1),
    .serial1_mode0(1'b0), .serial0_receive(s0_rx), .sda_level(sda_l), .scl_level(scl_l),
    .serial1_receive(s1_rx), .ext_int0_level(int0_l), .ext_int1_level(int1_l), .conversion_start_input(cnv_l),
    .external_data_move(xmove), .extmem_muxed(muxed), .extmem_upper(1'b0), .extmem_out(32'h0000_0000),
    .extmem_oe(xoe));
  pioxb_board board (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1;
    wvalid <= 1;
    // Each channel is held until its own ready is seen at an edge
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (awvalid && awready) begin
        aw_done = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        w_done = 1;
        wvalid <= 0;
      end
    end
    bready <= 1;
    do @(posedge core_clk); while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 0;
    rready <= 1;
    do @(posedge core_clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task automatic pass(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h08, d, r);
    `CHK("cfg_c", 32'h0000_0000, d)
    rd(8'h40, d, r);
    `CHK("mode0", 32'h0000_0000, d)
    rd(8'h60, d, r);
    `CHK("latch0", 32'h0000_00FF, d)
    wr(8'h18, 8'h55, r);
    `CHK("bresp", 2'b10, r)
    rd(8'h18, d, r);
    `CHK("rresp", 2'b10, r)
    $display("test reset done");
  endtask
  task automatic t_gpio;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h28, 8'h00, r);
    pass(1);
    `CHK("oe p2 off", 8'h00, pin_oe[23:16])
    wr(8'h08, 8'h40, r);
    pass(1);
    `CHK("oe p2 od", 8'hFF, pin_oe[23:16])
    `CHK("out p2 od", 8'h00, pin_out[23:16])
    wr(8'h48, 8'hFF, r);
    wr(8'h28, 8'hA5, r);
    pass(1);
    `CHK("oe p2 pp", 8'hFF, pin_oe[23:16])
    `CHK("out p2 pp", 8'hA5, pin_out[23:16])
    ext_val[31:24] <= 8'h0F;
    ext_en[31:24] <= 8'hFF;
    pass(6);
    `CHK("oe p3", 8'h00, pin_oe[31:24])
    rd(8'h2C, d, r);
    `CHK("pin p3", 32'h0000_000F, d)
    rd(8'h6C, d, r);
    `CHK("latch p3", 32'h0000_00FF, d)
    ext_en <= 0;
    $display("test gpio done");
  endtask
  task automatic t_serial;
    logic [1:0] r;
    wr(8'h20, 8'h00, r);
    wr(8'h00, 8'h04, r);
    s0_tx <= 0;
    ext_val[1] <= 0;
    ext_en[1] <= 1;
    pass(6);
    `CHK("tx oe", 1'b1, pin_oe[0])
    `CHK("rx oe", 1'b0, pin_oe[1])
    `CHK("rx level", 1'b0, s0_rx)
    @(posedge core_clk);
    s0_tx <= 1;
    pass(2);
    // Latch holds 0, yet the transmit line owns the pin
    `CHK("tx rel", 1'b0, pin_oe[0])
    wr(8'h00, 8'h00, r);
    pass(1);
    `CHK("rx free", 1'b1, s0_rx)
    `CHK("gpio oe", 2'b11, pin_oe[1:0])
    ext_en <= 0;
    $display("test serial done");
  endtask
  task automatic t_skip;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h0C, 8'hE3, r);
    muxed <= 1;
    wr(8'h00, 8'h05, r);
    wr(8'h04, 8'h14, r);
    wr(8'h08, 8'h46, r);
    wr(8'h40, 8'hFF, r);
    s1_tx <= 0;
    sda_d <= 1;
    scl_d <= 0;
    ext_en[13:8] <= 6'h23;
    pass(6);
    `CHK("s1 tx", 1'b1, pin_oe[4])
    // Push-pull port, yet the two-wire data pin only releases
    `CHK("sda od", 1'b0, pin_oe[2])
    `CHK("scl low", 2'h2, {pin_oe[3], pin_out[3]})
    `CHK("inputs", 6'h11, {s1_rx, sda_l, scl_l, int0_l, int1_l, cnv_l})
    `CHK("analog pu", 3'h0, pullup_en[12:10])
    rd(8'h24, d, r);
    `CHK("p1 pins", 32'h0000_00C0, d)
    $display("test skip done");
  endtask
  task automatic t_misc;
    logic [31:0] d;
    logic [1:0] r;
    s0_mode0 <= 1;
    s0_rxd <= 0;
    xmove <= 1;
    xoe <= 32'h0001_0000;
    pass(1);
    `CHK("rx m0 low", 2'h2, {pin_oe[1], pin_out[1]})
    `CHK("move pin", 2'h2, {pin_oe[16], pin_out[16]})
    @(posedge core_clk);
    s0_rxd <= 1;
    xmove <= 0;
    pass(1);
    `CHK("rx m0 high", 2'h0, {pin_oe[1], pin_out[1]})
    `CHK("move end", 2'h3, {pin_oe[16], pin_out[16]})
    @(posedge core_clk);
    s0_mode0 <= 0;
    wstrb <= 4'h0;
    wr(8'h28, 8'h00, r);
    `CHK("strb resp", 2'b00, r)
    wstrb <= 4'hF;
    wr(8'h14, 8'h10, r);
    pass(4);
    rd(8'h68, d, r);
    `CHK("latch p2", 32'h0000_00A4, d)
    rd(8'h14, d, r);
    `CHK("bit rd", 32'h0000_0010, d)
    $display("test misc done");
  endtask
  // ==========================================================
  // Run control
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1;
    t_reset();
    t_gpio();
    t_serial();
    t_skip();
    t_misc();
    stop_test();
  end
endmodule
